//--- rtl/tmo_pkg.sv
// constants for the timer match output control block
// assumes a single pclk domain and an apb master on the register side
package tmo_pkg;
	localparam int          TMO_NCH         = 4;
	localparam int          TMO_CW          = 32;
	// register byte offsets
	localparam logic [11:0] TMO_OFF_CTRL    = 12'h000; // external match control
	localparam logic [11:0] TMO_OFF_CNT     = 12'h004; // timer count value
	localparam logic [11:0] TMO_OFF_MATCH0  = 12'h008; // match value ch0, ch1..3 follow
	localparam logic [11:0] TMO_OFF_RUN     = 12'h018; // count enable
	// field positions in the control register
	localparam int          TMO_BIT_OUT     = 0;       // match bits 3:0
	localparam int          TMO_BIT_ACT     = 4;       // action fields from bit 4, two bits each
	localparam logic [31:0] TMO_CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] TMO_CTRL_MASK   = 32'h0000_0fff;
	localparam logic [31:0] TMO_CNT_RST     = 32'h0000_0000; // counter after reset
	localparam logic [31:0] TMO_MATCH_RST   = 32'h0000_0000; // match values after reset
	localparam logic        TMO_RUN_RST     = 1'b0;          // counter stopped after reset
	// action encodings
	typedef enum logic [1:0] {
		TMO_ACT_NONE   = 2'h0,
		TMO_ACT_LOW    = 2'h1,
		TMO_ACT_HIGH   = 2'h2,
		TMO_ACT_TOGGLE = 2'h3
	} tmo_act_t;
endpackage

//--- rtl/tmo_chan_if.sv
`timescale 1ns/1ps
// carries one channel's match request and result between top and action unit
// assumes both ends share pclk
interface tmo_chan_if;
	logic       hit;  // counter equals match value
	logic [1:0] act;  // action field
	logic       cur;  // present match bit
	logic       nxt;  // match bit after action
	modport top (output hit, output act, output cur, input nxt);
	modport unit (input hit, input act, input cur, output nxt);
endinterface

//--- rtl/tmo_action.sv
`timescale 1ns/1ps
// next value of one match output bit
// assumes hit is already qualified by the top
module tmo_action
	import tmo_pkg::*;
(
	tmo_chan_if.unit ch // channel link
);
	always_comb begin
		ch.nxt = ch.cur;
		if (ch.hit) begin
			case (tmo_act_t'(ch.act))
				TMO_ACT_LOW:    ch.nxt = 1'b0;
				TMO_ACT_HIGH:   ch.nxt = 1'b1;
				TMO_ACT_TOGGLE: ch.nxt = ~ch.cur;
				default:        ch.nxt = ch.cur;
			endcase
		end
	end
endmodule // tmo_action

//--- rtl/tmo_top.sv
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// apb slave with a 32-bit timer and four external match outputs
// assumes an apb master on pclk; pins are registered copies of the match bits, one pclk later
module tmo_top
	import tmo_pkg::*;
(
	input  wire logic        pclk,          // bus clock
	input  wire logic        presetn,       // async reset, active low
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb direction
	input  wire logic [11:0] paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error
	output logic             wave_out_pin0, // channel 0 pin
	output logic             wave_out_pin1, // channel 1 pin
	output logic             wave_out_pin2, // channel 2 pin
	output logic             wave_out_pin3  // channel 3 pin
);
	// register map, byte offsets on the bus
	//   control word  match bits 3:0, action fields 11:4
	//   counter       counts up while enabled, writable
	//   match bank    four words, channel 0 first
	//   run enable    bit 0 starts and stops the counter
	// other addresses answer with an error and read zero
	// whole words only; the two low address bits must be zero

	// control and timer state
	logic [31:0]        ctrl_r;              // control word
	logic [TMO_CW-1:0]  timer_count_value_r; // counter
	logic [TMO_CW-1:0]  match_r [TMO_NCH];   // match values
	logic               run_r;               // counter enable

	// match path
	logic [TMO_NCH-1:0] hit_vec;             // counter equals match value
	logic [TMO_NCH-1:0] out_nxt;             // match bits after actions

	// bus decode
	logic               setup_en;            // setup cycle of any transfer
	logic               wr_en;               // write access phase
	logic               rd_en;               // read setup cycle
	logic               wr_ctrl;             // write hits control word
	logic               wr_cnt;              // write hits counter
	logic               wr_match;            // write hits match bank
	logic               wr_run;              // write hits run enable
	logic [1:0]         word_idx;            // match word addressed
	logic               addr_ok;             // address is mapped
	logic [31:0]        rd_nxt;              // read data for this address

	// one link per channel to its action unit
	tmo_chan_if chan [TMO_NCH] ();

	// word inside the match bank, aligned
	function automatic logic is_match_addr(input logic [11:0] a);
		logic in_bank;
		in_bank = (a >= TMO_OFF_MATCH0) && (a < TMO_OFF_RUN);
		return in_bank && (a[1:0] == 2'h0);
	endfunction

	// channel number of a match bank word
	function automatic logic [1:0] match_index(input logic [11:0] a);
		logic [11:0] rel;
		rel = a - TMO_OFF_MATCH0;
		return rel[3:2];
	endfunction

	// match compare
	// only while counting: a stopped counter parked on a match
	// value would otherwise toggle its bit on every cycle
	always_comb begin
		for (int j = 0; j < TMO_NCH; j++) begin
			hit_vec[j] = run_r && (timer_count_value_r == match_r[j]);
		end
	end

	// action units, one per channel; each sees its own field
	// and present bit, and hands back the bit after the action
	for (genvar i = 0; i < TMO_NCH; i++) begin : g_ch
		assign chan[i].hit = hit_vec[i];
		assign chan[i].act = ctrl_r[TMO_BIT_ACT + 2*i +: 2];
		assign chan[i].cur = ctrl_r[TMO_BIT_OUT + i];
		assign out_nxt[i]  = chan[i].nxt;
		tmo_action u_act (
			.ch (chan[i])
		);
	end

	// apb phases; the slave always answers in the first access cycle,
	// so a write lands on the edge that samples ready high and read
	// data registered in setup stands exactly in that access cycle
	assign setup_en = psel && !penable;
	assign wr_en    = psel && penable && pwrite;
	assign rd_en    = setup_en && !pwrite;

	// write decode, one strobe per register
	always_comb begin
		wr_ctrl  = 1'b0;
		wr_cnt   = 1'b0;
		wr_match = 1'b0;
		wr_run   = 1'b0;
		if (wr_en) begin
			if (paddr == TMO_OFF_CTRL) begin
				wr_ctrl = 1'b1;
			end else if (paddr == TMO_OFF_CNT) begin
				wr_cnt = 1'b1;
			end else if (is_match_addr(paddr)) begin
				wr_match = 1'b1;
			end else if (paddr == TMO_OFF_RUN) begin
				wr_run = 1'b1;
			end
		end
	end

	// match word index, shared by writes and reads
	assign word_idx = match_index(paddr);

	// read decode and address check
	always_comb begin
		addr_ok = 1'b1;
		rd_nxt  = 32'h0000_0000;
		if (paddr == TMO_OFF_CTRL) begin
			rd_nxt = ctrl_r & TMO_CTRL_MASK;
		end else if (paddr == TMO_OFF_CNT) begin
			rd_nxt = timer_count_value_r;
		end else if (is_match_addr(paddr)) begin
			rd_nxt = match_r[word_idx];
		end else if (paddr == TMO_OFF_RUN) begin
			rd_nxt = {31'h0000_0000, run_r};
		end else begin
			addr_ok = 1'b0;
		end
	end

	// control word; a software write wins over a same-cycle match
	// so a freshly programmed start level is never lost to an action
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= TMO_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= pwdata & TMO_CTRL_MASK;
		end else begin
			ctrl_r[TMO_NCH-1:0] <= out_nxt;
		end
	end

	// counter, written by software, counts up while enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_count_value_r <= TMO_CNT_RST;
		end else if (wr_cnt) begin
			timer_count_value_r <= pwdata;
		end else if (run_r) begin
			timer_count_value_r <= timer_count_value_r + 32'h0000_0001;
		end
	end

	// match values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < TMO_NCH; k++) begin
				match_r[k] <= TMO_MATCH_RST;
			end
		end else if (wr_match) begin
			match_r[word_idx] <= pwdata;
		end
	end

	// run enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r <= TMO_RUN_RST;
		end else if (wr_run) begin
			run_r <= pwdata[0];
		end
	end

	// ready one cycle after setup, the access phase never waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_en;
		end
	end

	// error flag, raised with ready for an unmapped word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup_en && !addr_ok;
		end
	end

	// read data captured in setup, zero otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= rd_nxt;
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_out_pin3 <= TMO_CTRL_RST[TMO_BIT_OUT + 3];
		end else begin
			wave_out_pin3 <= ctrl_r[TMO_BIT_OUT + 3];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_out_pin2 <= TMO_CTRL_RST[TMO_BIT_OUT + 2];
		end else begin
			wave_out_pin2 <= ctrl_r[TMO_BIT_OUT + 2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_out_pin1 <= TMO_CTRL_RST[TMO_BIT_OUT + 1];
		end else begin
			wave_out_pin1 <= ctrl_r[TMO_BIT_OUT + 1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_out_pin0 <= TMO_CTRL_RST[TMO_BIT_OUT];
		end else begin
			wave_out_pin0 <= ctrl_r[TMO_BIT_OUT];
		end
	end
endmodule // tmo_top

//--- dv/tmo_chk.sv
// port checker for the match output block
// bound to tmo_top in the bench top file
`timescale 1ns/1ps
module tmo_chk
	import tmo_pkg::*;
(
	input wire logic        pclk,          // clock
	input wire logic        presetn,       // reset
	input wire logic        psel,          // select
	input wire logic        penable,       // access
	input wire logic        pwrite,        // direction
	input wire logic [11:0] paddr,         // address
	input wire logic [31:0] pwdata,        // wdata
	input wire logic [31:0] prdata,        // rdata
	input wire logic        pready,        // ready
	input wire logic        pslverr,       // error
	input wire logic        wave_out_pin0, // pin 0
	input wire logic        wave_out_pin1, // pin 1
	input wire logic        wave_out_pin2, // pin 2
	input wire logic        wave_out_pin3  // pin 3
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// accepted control write, then read
	sequence ctl_wr;
		psel && penable && pwrite && pready && paddr == TMO_OFF_CTRL;
	endsequence
	sequence ctl_rd;
		psel && penable && !pwrite && pready && paddr == TMO_OFF_CTRL;
	endsequence
	AST_PIN3: assert property (ctl_wr |-> ##2 wave_out_pin3 == $past(pwdata[3], 2))
		else $error("pin 3 off its match bit");
	AST_PIN2: assert property (ctl_wr |-> ##2 wave_out_pin2 == $past(pwdata[2], 2))
		else $error("pin 2 off its match bit");
	AST_PIN1: assert property (ctl_wr |-> ##2 wave_out_pin1 == $past(pwdata[1], 2))
		else $error("pin 1 off its match bit");
	AST_PIN0: assert property (ctl_wr |-> ##2 wave_out_pin0 == $past(pwdata[0], 2))
		else $error("pin 0 off its match bit");
	AST_RDY: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not one cycle after setup");
	AST_RD: assert property (ctl_rd |-> !pslverr && prdata[31:12] == 20'h0)
		else $error("control read upper bits set");
	AST_ERR: assert property (pready && paddr > TMO_OFF_RUN |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule // tmo_chk

//--- dv/tmo_pin_model.sv
// board side of the four wave outputs
// assumes the pins are sampled on pclk
`timescale 1ns/1ps
module tmo_pin_model (
	input wire logic       pclk, // clock
	input wire logic [3:0] pins, // wave outputs
	output logic     [3:0] seen  // sampled level
);
	always_ff @(posedge pclk) begin
		seen <= pins;
	end
endmodule // tmo_pin_model

//--- dv/tmo_top_tb.sv
// self-checking bench for tmo_top
// apb driven from pclk rising edges, pins read through the pin model
`timescale 1ns/1ps
module tmo_top_tb
	import tmo_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdata;
	wire  [3:0]  pins;
	logic [3:0]  seen;
	int          failures = 0, tests_run = 0, cyc = 0;
	// rows: expected match bits, then control word with start bits
	logic [15:0] rows [6] = '{16'hfff0, 16'h055f, 16'hfaa0, 16'ha00a, 16'haff5, 16'hce46};
	tmo_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.wave_out_pin0(pins[0]), .wave_out_pin1(pins[1]), .wave_out_pin2(pins[2]), .wave_out_pin3(pins[3]));
	tmo_pin_model pm (.pclk, .pins, .seen);
	always #50 pclk = ~pclk;
	// cycle ceiling against hangs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: pins %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{rerr, rdata} = {pslverr, prdata};
		{psel, penable} <= 2'b00;
	endtask
	task automatic finish_test();
		$display("tests_run %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, TMO_OFF_CTRL, '0);
		chk(rdata, 32'h0);
		apb(1'b0, 12'h01c, '0);
		chk({rerr, rdata[30:0]}, 32'h8000_0000);
		for (int i = 0; i < 4; i++) apb(1'b1, TMO_OFF_MATCH0 + 12'(4 * i), 32'h3);
		foreach (rows[i]) begin
			apb(1'b1, TMO_OFF_CNT, '0);
			apb(1'b1, TMO_OFF_CTRL, {20'h0, rows[i][11:0]});
			apb(1'b1, TMO_OFF_RUN, 32'h1);
			repeat (10) @(posedge pclk);
			apb(1'b1, TMO_OFF_RUN, '0);
			apb(1'b0, TMO_OFF_CTRL, '0);
			chk(rdata, {20'h0, rows[i][11:4], rows[i][15:12]});
			chk_pin(seen, rows[i][15:12]);
		end
		// register read back, run enable and a refused write
		apb(1'b1, TMO_OFF_CNT, 32'h1234_5678);
		apb(1'b0, TMO_OFF_CNT, '0);
		chk(rdata, 32'h1234_5678);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, TMO_OFF_MATCH0 + 12'(4 * i), '0);
			chk(rdata, 32'h3);
		end
		apb(1'b1, TMO_OFF_RUN, 32'h1);
		apb(1'b0, TMO_OFF_RUN, '0);
		chk(rdata, 32'h1);
		apb(1'b1, TMO_OFF_RUN, '0);
		apb(1'b1, 12'h01c, 32'hffff_ffff);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b0, TMO_OFF_CTRL, '0);
		chk(rdata, {20'h0, rows[5][11:4], rows[5][15:12]});
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, TMO_OFF_CTRL, '0);
		chk(rdata, 32'h0);
		chk_pin(seen, 4'h0);
		finish_test();
	end
endmodule // tmo_top_tb
bind tmo_top tmo_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.wave_out_pin0(wave_out_pin0), .wave_out_pin1(wave_out_pin1), .wave_out_pin2(wave_out_pin2),
	.wave_out_pin3(wave_out_pin3));
